// ---- core/gpc_consts.svh ----
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPC_OFF_DIR     8'h00
`define GPC_OFF_LAT     8'h04
`define GPC_OFF_PORT    8'h08
`define GPC_OFF_ODC     8'h0C
`define GPC_OFF_PCFG    8'h10
`define GPC_OFF_CHANGE_IRQ_ENABLE_1   8'h14
`define GPC_OFF_CHANGE_IRQ_ENABLE_2   8'h18
`define GPC_OFF_WEAK_PULLUP_ENABLE_1   8'h1C
`define GPC_OFF_WEAK_PULLUP_ENABLE_2   8'h20
`define GPC_OFF_PISEL0  8'h24
`define GPC_OFF_POSEL1  8'h28
`define GPC_OFF_POSEL2  8'h2C
`define GPC_OFF_STAT    8'h30
`define GPC_OFF_MASK    8'h34

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define GPC_RST_DIR     16'hFFFF
`define GPC_RST_ZERO    16'h0000
`define GPC_RST_PISEL   16'h1F00
`define GPC_PISEL_MASK  16'h1F00
`define GPC_POSEL_MASK  16'h1F1F
`define GPC_CN2_MASK    16'h001F
`define GPC_STAT_MASK   16'h0001

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define GPC_FLD_LO_LSB  0
`define GPC_FLD_HI_LSB  8
`define GPC_FLD_W       5
`define GPC_SEL_GND     5'h1F
`define GPC_ST_CHANGE   0

`endif

// ---- core/gpc_pin_drive.sv ----
`timescale 1ns/1ns
// Output mux for one port pin: latch or remapped peripheral, push-pull or open drain
module gpc_pin_drive
  import gpc_pkg::*;
#(
  parameter int NFUNC = 32
) (
  // Port controls
  input  wire logic             lat_bit,
  input  wire logic             dir_bit,
  input  wire logic             odc_bit,
  // Remapping
  input  wire gpc_func_type     func,
  input  wire logic [NFUNC-1:0] periph_out,
  // Pad drive
  output logic                  drv_out,
  output logic                  drv_oe
);
  wire       use_periph;
  wire       value;
  wire       want_drive;

  // Code zero leaves the pin to the latch and direction bit
  assign use_periph = (func != 5'h00);
  assign value      = use_periph ? periph_out[func] : lat_bit;
  assign want_drive = use_periph | ~dir_bit;
  // Open drain only ever pulls low; a high level floats for the external pull-up
  assign drv_out    = odc_bit ? 1'b0 : value;
  assign drv_oe     = want_drive & (odc_bit ? ~value : 1'b1);
endmodule // gpc_pin_drive

// ---- core/gpc_pkg.sv ----
package gpc_pkg;
  // Register word and output-function code
  typedef logic [15:0] gpc_word_type;
  typedef logic [4:0]  gpc_func_type;
endpackage

// ---- core/gpc_port.sv ----
`timescale 1ns/1ns
`include "gpc_consts.svh"
module gpc_port
  import gpc_pkg::*;
#(
  parameter int NPIN  = 16,
  parameter int NCN   = 21,
  parameter int NFUNC = 32
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Port pads
  input  wire logic [NPIN-1:0]  pad_in,
  output logic      [NPIN-1:0]  pad_out,
  output logic      [NPIN-1:0]  pad_oe,
  // Change-notify pads and pull-ups
  input  wire logic [NCN-1:0]   cn_pin_in,
  output logic      [NCN-1:0]   cn_pullup_en,
  // Peripherals and converter
  input  wire logic [NFUNC-1:0] periph_out,
  output logic      [NPIN-1:0]  adc_chan_en,
  output logic                  ext_irq1,
  // Interrupt
  output logic                  irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  gpc_word_type      dir_bits;
  gpc_word_type      out_lat;
  gpc_word_type      odc;
  gpc_word_type      pcfg;
  gpc_word_type      change_irq_enable_1;
  gpc_word_type      change_irq_enable_2;
  gpc_word_type      weak_pullup_enable_1;
  gpc_word_type      weak_pullup_enable_2;
  gpc_word_type      pisel0;
  gpc_word_type      posel1;
  gpc_word_type      posel2;
  gpc_word_type      stat;
  gpc_word_type      mask;
  logic [NPIN-1:0]   pad_meta;
  logic [NPIN-1:0]   pad_sync;
  logic [NCN-1:0]    cn_meta;
  logic [NCN-1:0]    cn_sync;
  logic [NCN-1:0]    cn_prev;
  logic [2:0]        cn_warm;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire               setup_ph;
  wire               wr_en;
  wire               sel_dir,    sel_lat,    sel_port,   sel_odc,    sel_pcfg;
  wire               sel_change_irq_enable_1,  sel_change_irq_enable_2,  sel_weak_pullup_enable_1,  sel_weak_pullup_enable_2,  sel_pisel;
  wire               sel_posel1, sel_posel2, sel_stat,   sel_mask;
  wire               sel_any;
  wire gpc_word_type wdata;
  wire gpc_word_type port_rd;
  wire gpc_word_type rd_word;

  // Zero-wait slave: data is captured in setup, answered in the first access cycle
  assign setup_ph   = psel & ~penable;
  assign wr_en      = psel & penable & pready & pwrite;
  assign wdata      = pwdata[15:0];
  assign sel_dir    = (paddr == `GPC_OFF_DIR);
  assign sel_lat    = (paddr == `GPC_OFF_LAT);
  assign sel_port   = (paddr == `GPC_OFF_PORT);
  assign sel_odc    = (paddr == `GPC_OFF_ODC);
  assign sel_pcfg   = (paddr == `GPC_OFF_PCFG);
  assign sel_change_irq_enable_1  = (paddr == `GPC_OFF_CHANGE_IRQ_ENABLE_1);
  assign sel_change_irq_enable_2  = (paddr == `GPC_OFF_CHANGE_IRQ_ENABLE_2);
  assign sel_weak_pullup_enable_1  = (paddr == `GPC_OFF_WEAK_PULLUP_ENABLE_1);
  assign sel_weak_pullup_enable_2  = (paddr == `GPC_OFF_WEAK_PULLUP_ENABLE_2);
  assign sel_pisel  = (paddr == `GPC_OFF_PISEL0);
  assign sel_posel1 = (paddr == `GPC_OFF_POSEL1);
  assign sel_posel2 = (paddr == `GPC_OFF_POSEL2);
  assign sel_stat   = (paddr == `GPC_OFF_STAT);
  assign sel_mask   = (paddr == `GPC_OFF_MASK);
  assign sel_any    = sel_dir | sel_lat | sel_port | sel_odc | sel_pcfg | sel_change_irq_enable_1
                    | sel_change_irq_enable_2 | sel_weak_pullup_enable_1 | sel_weak_pullup_enable_2 | sel_pisel | sel_posel1
                    | sel_posel2 | sel_stat | sel_mask;

  // Analog pins read low whatever the pad level (bit set = digital)
  assign port_rd = pad_sync & pcfg;

  // Read mux; reserved bits are already held at zero in the registers
  assign rd_word = sel_dir    ? dir_bits :
                   sel_lat    ? out_lat  :
                   sel_port   ? port_rd  :
                   sel_odc    ? odc      :
                   sel_pcfg   ? pcfg     :
                   sel_change_irq_enable_1  ? change_irq_enable_1    :
                   sel_change_irq_enable_2  ? change_irq_enable_2    :
                   sel_weak_pullup_enable_1  ? weak_pullup_enable_1    :
                   sel_weak_pullup_enable_2  ? weak_pullup_enable_2    :
                   sel_pisel  ? pisel0   :
                   sel_posel1 ? posel1   :
                   sel_posel2 ? posel2   :
                   sel_stat   ? stat     :
                   sel_mask   ? mask     : `GPC_RST_ZERO;

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~sel_any;
      if (setup_ph) begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // ----------------------------------------
  // Port control registers
  // ----------------------------------------
  // Port value writes land in the output latch, as on the real port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_bits <= `GPC_RST_DIR;
      out_lat  <= `GPC_RST_ZERO;
      odc      <= `GPC_RST_ZERO;
      pcfg     <= `GPC_RST_ZERO;
    end else begin
      if (wr_en && sel_dir) begin
        dir_bits <= wdata;
      end
      if (wr_en && (sel_lat || sel_port)) begin
        out_lat <= wdata;
      end
      if (wr_en && sel_odc) begin
        odc <= wdata;
      end
      if (wr_en && sel_pcfg) begin
        pcfg <= wdata;
      end
    end
  end

  // Change-notify enables and pull-ups; only 21 pins exist, upper bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq_enable_1 <= `GPC_RST_ZERO;
      change_irq_enable_2 <= `GPC_RST_ZERO;
      weak_pullup_enable_1 <= `GPC_RST_ZERO;
      weak_pullup_enable_2 <= `GPC_RST_ZERO;
    end else begin
      if (wr_en && sel_change_irq_enable_1) begin
        change_irq_enable_1 <= wdata;
      end
      if (wr_en && sel_change_irq_enable_2) begin
        change_irq_enable_2 <= wdata & `GPC_CN2_MASK;
      end
      if (wr_en && sel_weak_pullup_enable_1) begin
        weak_pullup_enable_1 <= wdata;
      end
      if (wr_en && sel_weak_pullup_enable_2) begin
        weak_pullup_enable_2 <= wdata & `GPC_CN2_MASK;
      end
    end
  end

  // Pin-select registers keep only their implemented fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pisel0 <= `GPC_RST_PISEL;
      posel1 <= `GPC_RST_ZERO;
      posel2 <= `GPC_RST_ZERO;
    end else begin
      if (wr_en && sel_pisel) begin
        pisel0 <= wdata & `GPC_PISEL_MASK;
      end
      if (wr_en && sel_posel1) begin
        posel1 <= wdata & `GPC_POSEL_MASK;
      end
      if (wr_en && sel_posel2) begin
        posel2 <= wdata & `GPC_POSEL_MASK;
      end
    end
  end

  // ----------------------------------------
  // Input synchronisers and change detection
  // ----------------------------------------
  wire [NCN-1:0]     cn_en;
  wire [NCN-1:0]     cn_pu;
  wire               change_hit;
  wire gpc_word_type stat_set;
  wire gpc_word_type stat_clr;
  wire gpc_word_type next_stat;

  assign cn_en      = {change_irq_enable_2[NCN-17:0], change_irq_enable_1};
  assign cn_pu      = {weak_pullup_enable_2[NCN-17:0], weak_pullup_enable_1};
  // Held off until both stages carry real pin levels, so a high idle pin
  // cannot look like a change just after reset
  assign change_hit = |((cn_sync ^ cn_prev) & cn_en) & cn_warm[2];
  assign stat_set   = {15'h0000, change_hit};
  assign stat_clr   = (wr_en && sel_stat) ? wdata : `GPC_RST_ZERO;
  // A new change wins over a clear in the same cycle
  assign next_stat  = ((stat & ~stat_clr) | stat_set) & `GPC_STAT_MASK;

  // Two flops on every pad before any logic sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_meta <= '0;
      pad_sync <= '0;
      cn_meta  <= '0;
      cn_sync  <= '0;
      cn_prev  <= '0;
      cn_warm  <= 3'b000;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
      cn_meta  <= cn_pin_in;
      cn_sync  <= cn_meta;
      cn_prev  <= cn_sync;
      cn_warm  <= {cn_warm[1:0], 1'b1};
    end
  end

  // Sticky change flag and its mask; needs a running clock, no wake in sleep here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= `GPC_RST_ZERO;
      mask <= `GPC_RST_ZERO;
    end else begin
      stat <= next_stat;
      if (wr_en && sel_mask) begin
        mask <= wdata & `GPC_STAT_MASK;
      end
    end
  end

  // ----------------------------------------
  // Pad drive, remapping and outputs
  // ----------------------------------------
  wire [NPIN-1:0]    next_pad_out;
  wire [NPIN-1:0]    next_pad_oe;
  wire [4:0]         ext_sel;
  wire               next_ext;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      wire gpc_func_type pin_func;
      // Pins 2 to 5 carry output-function fields; all others stay on the latch
      if (gi == 2) begin : g_f2
        assign pin_func = posel1[`GPC_FLD_LO_LSB +: `GPC_FLD_W];
      end else if (gi == 3) begin : g_f3
        assign pin_func = posel1[`GPC_FLD_HI_LSB +: `GPC_FLD_W];
      end else if (gi == 4) begin : g_f4
        assign pin_func = posel2[`GPC_FLD_LO_LSB +: `GPC_FLD_W];
      end else if (gi == 5) begin : g_f5
        assign pin_func = posel2[`GPC_FLD_HI_LSB +: `GPC_FLD_W];
      end else begin : g_fn
        assign pin_func = 5'h00;
      end
      gpc_pin_drive #(
        .NFUNC      (NFUNC)
      ) u_drive (
        .lat_bit    (out_lat[gi]),
        .dir_bit    (dir_bits[gi]),
        .odc_bit    (odc[gi]),
        .func       (pin_func),
        .periph_out (periph_out),
        .drv_out    (next_pad_out[gi]),
        .drv_oe     (next_pad_oe[gi])
      );
    end
  endgenerate

  // Codes 16 to 30 name no pin and read as low, like the ground code
  assign ext_sel  = pisel0[`GPC_FLD_HI_LSB +: `GPC_FLD_W];
  assign next_ext = (ext_sel == `GPC_SEL_GND) ? 1'b0 :
                    ext_sel[4]                ? 1'b0 : pad_sync[ext_sel[3:0]];

  // Every top-level output leaves from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out      <= '0;
      pad_oe       <= '0;
      cn_pullup_en <= '0;
      adc_chan_en  <= '0;
      ext_irq1     <= 1'b0;
      irq          <= 1'b0;
    end else begin
      pad_out      <= next_pad_out;
      pad_oe       <= next_pad_oe;
      cn_pullup_en <= cn_pu;
      adc_chan_en  <= ~pcfg;
      ext_irq1     <= next_ext;
      irq          <= |(next_stat & mask);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_OD_NEVER_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pad_oe & pad_out & $past(odc)) == '0))
    else $error("open-drain pin driven high");
  AST_PCFG_RESET: assert property (@(posedge pclk)
    $rose(presetn) |-> (pcfg == `GPC_RST_ZERO))
    else $error("analog config not zero after reset");
  AST_PORT_ANALOG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && sel_port) |=> ((prdata[15:0] & ~$past(pcfg)) == 16'h0000))
    else $error("analog pin read as nonzero");
  AST_ADC_DIGITAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((adc_chan_en & $past(pcfg)) == '0))
    else $error("digital pin feeds converter");
  AST_CHANGE_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    change_hit |=> stat[`GPC_ST_CHANGE] ##0 (irq == $past(mask[`GPC_ST_CHANGE])))
    else $error("change not latched");
  AST_CHANGE_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    (cn_en == '0 && !stat[`GPC_ST_CHANGE]) |=> !stat[`GPC_ST_CHANGE])
    else $error("change flag set with enables clear");
  AST_CHANGE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (stat[`GPC_ST_CHANGE] && !(wr_en && sel_stat)) |=> stat[`GPC_ST_CHANGE])
    else $error("change flag dropped without clear");
  AST_PULLUP_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (cn_pullup_en == $past(cn_pu)))
    else $error("pull-up does not follow enable");
  AST_EXT_GROUND: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_sel == `GPC_SEL_GND) [*2] |-> !ext_irq1)
    else $error("grounded ext interrupt input is high");
  AST_SEL_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    ((pisel0 & ~`GPC_PISEL_MASK) == 16'h0000) && ((posel1 & ~`GPC_POSEL_MASK) == 16'h0000))
    else $error("unimplemented select bits set");
  AST_FUNC_ZERO_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (posel1[4:0] == 5'h00 && !dir_bits[2] && !odc[2])
      |=> (pad_oe[2] && (pad_out[2] == $past(out_lat[2]))))
    else $error("function zero pin not on latch");
endmodule // gpc_port

// ---- tb/gpc_pad_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Pads and peripherals outside the port block
// ----------------------------------------
module gpc_pad_model
  import gpc_pkg::*;
#(
  parameter int          NPIN       = 16,
  parameter int          NCN        = 21,
  parameter int          NFUNC      = 32,
  parameter logic [31:0] PERIPH_PAT = 32'hA5C3_0FB6
) (
  // Port pads as the block drives them
  input  wire logic [NPIN-1:0]  pad_out,
  input  wire logic [NPIN-1:0]  pad_oe,
  // Levels forced by board parts when the block lets go
  input  wire logic [NPIN-1:0]  pad_ext,
  output logic      [NPIN-1:0]  pad_in,
  // Change-notify pads
  input  wire logic [NCN-1:0]   cn_ext,
  output logic      [NCN-1:0]   cn_pin_in,
  // Peripheral function outputs, pattern or its inverse
  input  wire logic             periph_inv,
  output logic      [NFUNC-1:0] periph_out
);
  // Resolved pad level: a released or open-drain high pin shows the board
  // level (pull-up resistors), never a stale copy of the last driven value
  wire logic [NPIN-1:0] drv_lvl = pad_oe & pad_out;
  wire logic [NPIN-1:0] brd_lvl = ~pad_oe & pad_ext;

  // Wire levels and fixed peripheral pattern
  assign pad_in     = drv_lvl | brd_lvl;
  assign cn_pin_in  = cn_ext;
  assign periph_out = PERIPH_PAT[NFUNC-1:0] ^ {NFUNC{periph_inv}};
endmodule // gpc_pad_model

// ---- tb/io_port_pin_config_tb.sv ----
`timescale 1ns/1ns
`include "gpc_consts.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module io_port_pin_config_tb;
  import gpc_pkg::*;
  localparam logic [31:0] PAT = 32'hA5C3_0FB6;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic         pclk    = 1'b0;
  logic         presetn = 1'b0;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [7:0]   paddr   = 8'h00;
  logic [31:0]  pwdata  = 32'h0000_0000;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  pad_ext = 16'hFFFF;
  logic [15:0]  pad_in;
  logic [15:0]  pad_out;
  logic [15:0]  pad_oe;
  logic [20:0]  cn_ext  = 21'h000000;
  logic         periph_inv = 1'b0;
  logic [20:0]  cn_pin_in;
  logic [20:0]  cn_pullup_en;
  logic [31:0]  periph_out;
  logic [15:0]  adc_chan_en;
  logic         ext_irq1;
  logic         irq;
  int           err_total = 0;
  int           n_tests   = 0;
  gpc_word_type rdv;
  logic         rerr;
  logic [7:0]   rst_addr [13] = '{`GPC_OFF_DIR, `GPC_OFF_LAT, `GPC_OFF_ODC, `GPC_OFF_PCFG,
    `GPC_OFF_CHANGE_IRQ_ENABLE_1, `GPC_OFF_CHANGE_IRQ_ENABLE_2, `GPC_OFF_WEAK_PULLUP_ENABLE_1, `GPC_OFF_WEAK_PULLUP_ENABLE_2, `GPC_OFF_PISEL0,
    `GPC_OFF_POSEL1, `GPC_OFF_POSEL2, `GPC_OFF_STAT, `GPC_OFF_MASK};
  gpc_word_type rst_val  [13] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h1F00, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0]   msk_addr [5]  = '{`GPC_OFF_PISEL0, `GPC_OFF_POSEL1, `GPC_OFF_POSEL2,
    `GPC_OFF_CHANGE_IRQ_ENABLE_2, `GPC_OFF_WEAK_PULLUP_ENABLE_2};
  gpc_word_type msk_val  [5]  = '{16'h1F00, 16'h1F1F, 16'h1F1F, 16'h001F, 16'h001F};

  // Clock at 250 MHz
  always #2 pclk = ~pclk;

  // ----------------------------------------
  // Block and its surroundings
  // ----------------------------------------
  gpc_port dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .cn_pin_in(cn_pin_in),
    .cn_pullup_en(cn_pullup_en), .periph_out(periph_out), .adc_chan_en(adc_chan_en),
    .ext_irq1(ext_irq1), .irq(irq));

  gpc_pad_model #(.PERIPH_PAT(PAT)) u_pads (
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_ext(pad_ext), .pad_in(pad_in),
    .cn_ext(cn_ext), .cn_pin_in(cn_pin_in), .periph_inv(periph_inv),
    .periph_out(periph_out));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; every task ends just after an edge, so the next call
  // always leaves an idle cycle, which also keeps the write-then-read gap
  task automatic xfer(input logic wr, input logic [7:0] a, input gpc_word_type d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count is assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    `CHK(pready, 1'b1)
    rdv  = prdata[15:0];
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input gpc_word_type d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input gpc_word_type exp);
    xfer(1'b0, a, 16'h0000);
    `CHK(rdv, exp)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(2);
    `CHK(pad_oe, 16'h0000)
    `CHK(adc_chan_en, 16'hFFFF)
    for (int i = 0; i < 13; i++) begin
      rd_chk(rst_addr[i], rst_val[i]);
    end
    // Unimplemented bits read zero; pull-ups follow their enable bits
    for (int i = 0; i < 5; i++) begin
      wr(msk_addr[i], 16'hFFFF);
      rd_chk(msk_addr[i], msk_val[i]);
    end
    wr(`GPC_OFF_WEAK_PULLUP_ENABLE_1, 16'h8001);
    cyc(2);
    `CHK(cn_pullup_en, 21'h1F8001)
    wr(`GPC_OFF_POSEL1, 16'h0000);
    wr(`GPC_OFF_POSEL2, 16'h0000);
    // Unmapped word refused
    xfer(1'b0, 8'h3C, 16'h0000);
    `CHK(rerr, 1'b1)
    `CHK(rdv, 16'h0000)
    // Analog pins read low and feed the converter; direction kept input
    rd_chk(`GPC_OFF_PORT, 16'h0000);
    wr(`GPC_OFF_PCFG, 16'h00FF);
    cyc(4);
    rd_chk(`GPC_OFF_PORT, 16'h00FF);
    `CHK(adc_chan_en, 16'hFF00)
    wr(`GPC_OFF_PCFG, 16'hFFFF);
    wr(`GPC_OFF_WEAK_PULLUP_ENABLE_1, 16'h0000);
    // Open drain: high latch bits release the pin, board pull-up reads back
    wr(`GPC_OFF_LAT, 16'h0FF0);
    wr(`GPC_OFF_ODC, 16'h0F0F);
    wr(`GPC_OFF_DIR, 16'h0000);
    cyc(2);
    `CHK(pad_oe, 16'hF0FF)
    `CHK(pad_out & pad_oe, 16'h00F0)
    cyc(3);
    rd_chk(`GPC_OFF_PORT, 16'h0FF0);
    wr(`GPC_OFF_ODC, 16'h0000);
    cyc(2);
    `CHK(pad_oe, 16'hFFFF)
    `CHK(pad_out, 16'h0FF0)
    wr(`GPC_OFF_DIR, 16'hFFFF);
    // Remapped outputs override the direction bits
    wr(`GPC_OFF_POSEL1, 16'h0005);
    wr(`GPC_OFF_POSEL2, 16'h1F00);
    cyc(2);
    `CHK(pad_oe, 16'h0024)
    `CHK(pad_out & 16'h0024, {10'h000, PAT[31], 2'b00, PAT[5], 2'b00})
    periph_inv <= 1'b1;
    cyc(2);
    `CHK(pad_out & 16'h0024, {10'h000, ~PAT[31], 2'b00, ~PAT[5], 2'b00})
    periph_inv <= 1'b0;
    wr(`GPC_OFF_POSEL1, 16'h0000);
    wr(`GPC_OFF_POSEL2, 16'h0000);
    cyc(2);
    `CHK(pad_oe, 16'h0000)
    // External interrupt 1 follows the selected pin, one-hot levels
    for (int n = 0; n < 16; n++) begin
      pad_ext <= 16'h0001 << n;
      wr(`GPC_OFF_PISEL0, {3'b000, 5'(n), 8'h00});
      cyc(5);
      `CHK(ext_irq1, 1'b1)
    end
    wr(`GPC_OFF_PISEL0, 16'h1F00);
    pad_ext <= 16'hFFFF;
    cyc(5);
    `CHK(ext_irq1, 1'b0)
    // Change notification: disabled pin, enabled pin, sticky flag, mask
    wr(`GPC_OFF_CHANGE_IRQ_ENABLE_2, 16'h0010);
    wr(`GPC_OFF_MASK, 16'h0001);
    cn_ext <= 21'h000002;
    cyc(6);
    rd_chk(`GPC_OFF_STAT, 16'h0000);
    `CHK(irq, 1'b0)
    cn_ext <= 21'h100002;
    cyc(6);
    `CHK(irq, 1'b1)
    rd_chk(`GPC_OFF_STAT, 16'h0001);
    cn_ext <= 21'h000002;
    cyc(6);
    wr(`GPC_OFF_STAT, 16'h0001);
    rd_chk(`GPC_OFF_STAT, 16'h0000);
    `CHK(irq, 1'b0)
    wr(`GPC_OFF_CHANGE_IRQ_ENABLE_1, 16'h0001);
    wr(`GPC_OFF_MASK, 16'h0000);
    cn_ext <= 21'h000003;
    cyc(6);
    `CHK(irq, 1'b0)
    rd_chk(`GPC_OFF_STAT, 16'h0001);
    wr(`GPC_OFF_MASK, 16'h0001);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(`GPC_OFF_STAT, 16'h0001);
    cyc(2);
    `CHK(irq, 1'b0)
    results();
  end
endmodule // io_port_pin_config_tb
